// *** hdl/fgpm_cfg.svh ***
// Constants of the fine-grain packet mapper: codes, field positions, counts.
// Included by the package, the mapper and the bench; definitions only.
`ifndef FGPM_CFG_SVH
`define FGPM_CFG_SVH
`define FGPM_PT_PRBS 6'h3E
`define FGPM_PT_PKT 6'h02
`define FGPM_PT_MSB 5
`define FGPM_CSF_BIT 7
`define FGPM_MFC_LAST 4'hA
`define FGPM_MF_BLOCKS 15'h4F00
`define FGPM_PL_BYTES 14'h3B40
`define FGPM_HDR_DATA 2'h2
`define FGPM_HDR_CTRL 2'h1
`define FGPM_TYPE_IDLE 8'h1E
`define FGPM_TYPE_START 8'h78
`define FGPM_TYPE_OSET 8'h4B
`define FGPM_IDLE_BLK 64'h0000_0000_0000_001E
`define FGPM_LF_BLK 64'h0000_0000_0100_004B
`define FGPM_ERR_BLK {{8{7'h1E}}, 8'h1E}
`define FGPM_PREAMBLE 56'hD5_5555_5555_5555
`define FGPM_CRC_LO 8
`define FGPM_CRC_POLY 32'h04C1_1DB7
`define FGPM_CRC_INIT 32'hFFFF_FFFF
`define FGPM_PRBS_INIT 31'h7FFF_FFFF
`define FGPM_STAT_AIS 3'h7
`define FGPM_STAT_OCI 3'h6
`define FGPM_STAT_LCK 3'h5
`endif

// *** hdl/fgpm_pkg.sv ***
// Types and helper functions shared by the fine-grain packet mapper.
// Assumes fgpm_cfg.svh is on the include path.
`include "fgpm_cfg.svh"
package fgpm_pkg;
    typedef logic [65:0] fgpm_blk_type;
    typedef enum logic [1:0] {FGPM_IDLE, FGPM_PKT, FGPM_PEND} fgpm_st_type;

    // Octets are fed most significant bit first, byte 0 first
    function automatic logic [31:0] fgpm_crc(input logic [31:0] c, input logic [63:0] d);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 64; i++) begin
            fb = r[31] ^ d[(i / 8) * 8 + 7 - (i % 8)];
            r = {r[30:0], 1'b0};
            if (fb) begin
                r = r ^ `FGPM_CRC_POLY;
            end
        end
        return r;
    endfunction

    function automatic logic fgpm_is_term(input logic [7:0] t);
        return t == 8'h87 || t == 8'h99 || t == 8'hAA || t == 8'hB4 ||
            t == 8'hCC || t == 8'hD2 || t == 8'hE1 || t == 8'hFF;
    endfunction

    function automatic logic [5:0] fgpm_first_off(input logic [3:0] m);
        case (m)
            4'h0: return 6'h00;
            4'h1: return 6'h24;
            4'h2: return 6'h06;
            4'h3: return 6'h2A;
            4'h4: return 6'h0C;
            4'h5: return 6'h30;
            4'h6: return 6'h12;
            4'h7: return 6'h36;
            4'h8: return 6'h18;
            4'h9: return 6'h3C;
            default: return 6'h1E;
        endcase
    endfunction
endpackage

// *** hdl/fgpm_top.sv ***
// Fine-grain payload mapper and demapper for 64B/66B packet and PRBS clients.
// Assumes framer strobes and overhead fields on the same clock; one block per take.
// Contract
// - Detect alarm, open-connection and locked from status bits of path and tandem fields.
// - Maintenance timed from a server clock uses the nominal justification ratio.
// - Test mode fills payload bytes with eight bits each of a 2^31-1 sequence.
// - Test mode overhead carries type 0x3E; payload is four rows of 3792 bytes.
// - Start blocks carry preamble and start frame delimiter.
// - Idle blocks are inserted or deleted to match payload capacity.
// - CRC-32 Ethernet polynomial, octets fed MSB first, after rate adaptation.
// - Checksum covers data and terminate blocks, not sync headers.
// - Checksum x31..x0 goes in bits 10..41 of idle or start after terminate.
// - 20224 blocks aligned to an 11-frame multiframe.
// - First block offset per counter value: 0,36,6,42,12,48,18,54,24,60,30.
// - Sink checks, marks and restores before any rate adaptation.
// - On checksum failure last data block before terminate becomes error block.
// - Sink restores bits 10..41 to idle codes or preamble.
// - Packet overhead: type 0x02, client fail, counter 0..10 advancing each frame.
// - Failed client is replaced by local fault ordered-set blocks.
// - Alarm, locked or open-connection input makes sink emit local fault blocks.
// - Payload type sits in bits 3..8 of the row 4 column 15 byte.
// - Client fail bit 1 of that byte is one while client failed; the mapper forces it to zero in test mode.
`timescale 1ns/1ps
`include "fgpm_cfg.svh"
module fgpm_top
    import fgpm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic test_mode,
    input wire logic srv_timed,
    input wire logic cli_fail,
    input wire logic cli_valid,
    input wire logic [1:0] cli_hdr,
    input wire logic [63:0] cli_data,
    output logic cli_ready,
    input wire logic map_take,
    input wire logic frame_sof,
    output logic map_valid,
    output logic [1:0] map_hdr,
    output logic [63:0] map_data,
    output logic mf_first_blk,
    output logic [7:0] ovh_c15,
    output logic [7:0] payload_multiframe_counter,
    output logic [5:0] first_blk_offset,
    input wire logic prbs_take,
    output logic [7:0] prbs_byte,
    output logic prbs_last,
    output logic nominal_just,
    input wire logic dm_sof,
    input wire logic [2:0] path_monitor_field,
    input wire logic [2:0] tandem_monitor_one,
    input wire logic [2:0] tandem_monitor_two,
    input wire logic dm_valid,
    input wire logic [1:0] dm_hdr,
    input wire logic [63:0] dm_data,
    output logic dm_out_valid,
    output logic [1:0] dm_out_hdr,
    output logic [63:0] dm_out_data,
    output logic crc_err,
    output logic path_alarm_indication,
    output logic path_open_connection,
    output logic path_locked_indication
);
    logic hold_full_reg;
    fgpm_blk_type hold_reg;
    logic cli_ready_reg;
    fgpm_st_type map_st_reg;
    logic [31:0] map_crc_reg;
    logic [3:0] mfc_reg;
    logic [14:0] blk_cnt_reg;
    logic [30:0] prbs_reg;
    logic [13:0] pl_cnt_reg;
    fgpm_st_type dm_st_reg;
    logic [31:0] dm_crc_reg;
    fgpm_blk_type s0_reg, s1_reg, s2_reg;
    logic [2:0] sv_reg;
    fgpm_blk_type blk_next;
    logic [31:0] crc_next;
    logic [3:0] mfc_next;
    logic cli_acc, is_ctl, is_d, is_t, is_i, is_s, maint;

    assign cli_acc = cli_valid && cli_ready_reg;
    assign maint = path_alarm_indication || path_open_connection || path_locked_indication;

    // Block handed to the framer on this slot: fail fill, held client block or inserted idle
    always_comb begin
        blk_next = {`FGPM_IDLE_BLK, `FGPM_HDR_CTRL};
        if (cli_fail) begin
            blk_next = {`FGPM_LF_BLK, `FGPM_HDR_CTRL};
        end else if (hold_full_reg) begin
            blk_next = hold_reg;
        end
        is_ctl = blk_next[1:0] == `FGPM_HDR_CTRL;
        is_d = blk_next[1:0] == `FGPM_HDR_DATA;
        is_t = is_ctl && fgpm_is_term(blk_next[9:2]);
        is_i = is_ctl && blk_next[9:2] == `FGPM_TYPE_IDLE;
        is_s = is_ctl && blk_next[9:2] == `FGPM_TYPE_START;
        if (is_s) begin
            blk_next[65:10] = `FGPM_PREAMBLE;
        end
        crc_next = fgpm_crc(map_st_reg == FGPM_PKT ? map_crc_reg : `FGPM_CRC_INIT,
            blk_next[65:2]);
        if (map_st_reg == FGPM_PEND && (is_i || is_s)) begin
            for (int i = 0; i < 32; i++) begin
                blk_next[2 + `FGPM_CRC_LO + i] = map_crc_reg[31 - i];
            end
        end
    end

    // One-block hold; an idle sitting in it is overwritten, which deletes it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_full_reg <= 1'b0;
            hold_reg <= '0;
            cli_ready_reg <= 1'b0;
        end else begin
            if (cli_acc) begin
                hold_full_reg <= 1'b1;
                hold_reg <= {cli_data, cli_hdr};
            end else if (map_take && !test_mode) begin
                hold_full_reg <= 1'b0;
            end
            if (cli_acc) begin
                cli_ready_reg <= cli_hdr == `FGPM_HDR_CTRL && cli_data[7:0] == `FGPM_TYPE_IDLE;
            end else begin
                cli_ready_reg <= !hold_full_reg || (map_take && !test_mode) ||
                    hold_reg[9:2] == `FGPM_TYPE_IDLE && hold_reg[1:0] == `FGPM_HDR_CTRL;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            map_st_reg <= FGPM_IDLE;
            map_crc_reg <= `FGPM_CRC_INIT;
            map_valid <= 1'b0;
            map_hdr <= '0;
            map_data <= '0;
        end else begin
            map_valid <= map_take && !test_mode;
            if (map_take && !test_mode) begin
                map_hdr <= blk_next[1:0];
                map_data <= blk_next[65:2];
                if (is_d || is_t) begin
                    map_crc_reg <= crc_next;
                    map_st_reg <= is_t ? FGPM_PEND : FGPM_PKT;
                end else if (is_s || is_i || blk_next[9:2] == `FGPM_TYPE_OSET) begin
                    map_st_reg <= FGPM_IDLE;
                    map_crc_reg <= `FGPM_CRC_INIT;
                end
            end
        end
    end

    assign mfc_next = (mfc_reg == `FGPM_MFC_LAST) ? 4'h0 : mfc_reg + 4'h1;

    // Frame overhead and multiframe alignment
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mfc_reg <= `FGPM_MFC_LAST;
            blk_cnt_reg <= '0;
            mf_first_blk <= 1'b0;
            ovh_c15 <= '0;
            payload_multiframe_counter <= '0;
            first_blk_offset <= '0;
            nominal_just <= 1'b0;
        end else begin
            mf_first_blk <= map_take && !test_mode && blk_cnt_reg == '0;
            if (frame_sof) begin
                mfc_reg <= mfc_next;
                payload_multiframe_counter <= {4'h0, mfc_next};
                first_blk_offset <= fgpm_first_off(mfc_next);
                ovh_c15[`FGPM_PT_MSB:0] <= test_mode ? `FGPM_PT_PRBS : `FGPM_PT_PKT;
                ovh_c15[`FGPM_CSF_BIT] <= cli_fail && !test_mode;
            end
            if (frame_sof && mfc_next == 4'h0) begin
                blk_cnt_reg <= '0;
            end else if (map_take && !test_mode) begin
                blk_cnt_reg <= (blk_cnt_reg == `FGPM_MF_BLOCKS - 15'h1) ? '0
                    : blk_cnt_reg + 15'h1;
            end
            nominal_just <= srv_timed && (maint || cli_fail);
        end
    end

    // Test pattern generator, x^31 + x^28 + 1, eight bits per payload byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prbs_reg <= `FGPM_PRBS_INIT;
            prbs_byte <= '0;
            pl_cnt_reg <= '0;
            prbs_last <= 1'b0;
        end else begin
            prbs_last <= 1'b0;
            if (prbs_take && test_mode) begin
                for (int i = 0; i < 8; i++) begin
                    prbs_byte[7 - i] <= prbs_reg[30 - i] ^ prbs_reg[27 - i];
                end
                prbs_reg <= {prbs_reg[22:0], prbs_reg[30:23] ^ prbs_reg[27:20]};
                prbs_last <= pl_cnt_reg == `FGPM_PL_BYTES - 14'h1;
                pl_cnt_reg <= (pl_cnt_reg == `FGPM_PL_BYTES - 14'h1) ? '0
                    : pl_cnt_reg + 14'h1;
            end
        end
    end

    assign cli_ready = cli_ready_reg;

    // Maintenance detection on the three status fields, taken at each sink frame
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            path_alarm_indication <= 1'b0;
            path_open_connection <= 1'b0;
            path_locked_indication <= 1'b0;
        end else if (dm_sof) begin
            path_alarm_indication <= path_monitor_field == `FGPM_STAT_AIS ||
                tandem_monitor_one == `FGPM_STAT_AIS ||
                tandem_monitor_two == `FGPM_STAT_AIS;
            path_open_connection <= path_monitor_field == `FGPM_STAT_OCI ||
                tandem_monitor_one == `FGPM_STAT_OCI ||
                tandem_monitor_two == `FGPM_STAT_OCI;
            path_locked_indication <= path_monitor_field == `FGPM_STAT_LCK ||
                tandem_monitor_one == `FGPM_STAT_LCK ||
                tandem_monitor_two == `FGPM_STAT_LCK;
        end
    end

    // Sink: three-block delay so the last data block can still be marked
    logic in_ctl, in_d, in_t, in_i, in_s, in_bad;
    logic [31:0] dm_crc_next, rx_crc;
    fgpm_blk_type in_blk;
    always_comb begin
        in_ctl = dm_hdr == `FGPM_HDR_CTRL;
        in_d = dm_hdr == `FGPM_HDR_DATA;
        in_t = in_ctl && fgpm_is_term(dm_data[7:0]);
        in_i = in_ctl && dm_data[7:0] == `FGPM_TYPE_IDLE;
        in_s = in_ctl && dm_data[7:0] == `FGPM_TYPE_START;
        dm_crc_next = fgpm_crc(dm_st_reg == FGPM_PKT ? dm_crc_reg : `FGPM_CRC_INIT, dm_data);
        for (int i = 0; i < 32; i++) begin
            rx_crc[31 - i] = dm_data[`FGPM_CRC_LO + i];
        end
        in_bad = dm_st_reg == FGPM_PEND && (in_i || in_s) && rx_crc != dm_crc_reg;
        in_blk = {dm_data, dm_hdr};
        if (dm_st_reg == FGPM_PEND && in_i) begin
            in_blk[41:10] = '0;
        end else if (dm_st_reg == FGPM_PEND && in_s) begin
            in_blk[41:10] = 32'(`FGPM_PREAMBLE);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_st_reg <= FGPM_IDLE;
            dm_crc_reg <= `FGPM_CRC_INIT;
            s0_reg <= '0;
            s1_reg <= '0;
            s2_reg <= '0;
            sv_reg <= '0;
            crc_err <= 1'b0;
        end else begin
            crc_err <= dm_valid && in_bad;
            if (dm_valid) begin
                sv_reg <= {sv_reg[1:0], 1'b1};
                s0_reg <= in_blk;
                s1_reg <= s0_reg;
                s2_reg <= s1_reg;
                if (in_bad && s1_reg[1:0] == `FGPM_HDR_DATA) begin
                    s2_reg <= {`FGPM_ERR_BLK, `FGPM_HDR_CTRL};
                end
                if (in_d || in_t) begin
                    dm_crc_reg <= dm_crc_next;
                    dm_st_reg <= in_t ? FGPM_PEND : FGPM_PKT;
                end else if (in_ctl) begin
                    dm_st_reg <= FGPM_IDLE;
                    dm_crc_reg <= `FGPM_CRC_INIT;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_out_valid <= 1'b0;
            dm_out_hdr <= '0;
            dm_out_data <= '0;
        end else begin
            dm_out_valid <= dm_valid && (sv_reg[2] || maint);
            if (dm_valid && maint) begin
                dm_out_hdr <= `FGPM_HDR_CTRL;
                dm_out_data <= `FGPM_LF_BLK;
            end else if (dm_valid) begin
                dm_out_hdr <= s2_reg[1:0];
                dm_out_data <= s2_reg[65:2];
            end
        end
    end

    a_mfc_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        frame_sof && mfc_reg == `FGPM_MFC_LAST |=> payload_multiframe_counter == 8'h00)
        else $error("multiframe counter did not wrap");
    a_mfc_range: assert property (@(posedge clk) disable iff (sys_rst)
        payload_multiframe_counter <= 8'h0A) else $error("counter out of range");
    a_offset_map: assert property (@(posedge clk) disable iff (sys_rst)
        frame_sof ##1 payload_multiframe_counter == 8'h01 |-> first_blk_offset == 6'h24)
        else $error("wrong first block offset");
    a_pt_code: assert property (@(posedge clk) disable iff (sys_rst)
        frame_sof && test_mode |=> ovh_c15[5:0] == 6'h3E) else $error("wrong test type");
    a_csf_follow: assert property (@(posedge clk) disable iff (sys_rst)
        frame_sof && !test_mode |=> ovh_c15[7] == $past(cli_fail))
        else $error("client fail bit wrong");
    a_fail_fill: assert property (@(posedge clk) disable iff (sys_rst)
        map_take && !test_mode && cli_fail |=> map_data == `FGPM_LF_BLK && map_valid)
        else $error("fail fill missing");
    a_sink_fill: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid && path_alarm_indication |=> dm_out_data == `FGPM_LF_BLK)
        else $error("sink fill missing");
    a_mark_err: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid && in_bad && s1_reg[1:0] == `FGPM_HDR_DATA && !maint
        ##1 dm_valid && !maint |=> dm_out_data == `FGPM_ERR_BLK)
        else $error("errored packet not marked");
    a_ais_detect: assert property (@(posedge clk) disable iff (sys_rst)
        dm_sof && tandem_monitor_two == `FGPM_STAT_AIS |=> path_alarm_indication)
        else $error("alarm not detected");
    a_no_pkt_test: assert property (@(posedge clk) disable iff (sys_rst)
        test_mode |=> !map_valid) else $error("block output in test mode");
endmodule

// *** verification/fgpm_framer_model.sv ***
// Framer slot model: turns a one-cycle slot request into one map_take pulse.
// Assumes requests arrive by non-blocking assignment on the falling edge.
`timescale 1ns/1ps
module fgpm_framer_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slot_req,
    input wire logic [3:0] slot_delay,
    output logic map_take
);
    logic pend_reg;
    logic [3:0] cnt_reg;

    // Falling edge drive so the mapper samples a settled take
    always_ff @(negedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            map_take <= 1'b0;
            pend_reg <= 1'b0;
            cnt_reg <= 4'h0;
        end else begin
            map_take <= 1'b0;
            if (pend_reg) begin
                if (cnt_reg == 4'h0) begin
                    map_take <= 1'b1;
                    pend_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end else if (slot_req) begin
                pend_reg <= 1'b1;
                cnt_reg <= slot_delay;
            end
        end
    end
endmodule

// *** verification/fgpm_top_tb_top.sv ***
// Self-checking bench for the fine-grain packet mapper and demapper.
// Assumes fgpm_cfg.svh on the include path; a framer model issues slot takes.
`timescale 1ns/1ps
`include "fgpm_cfg.svh"
module fgpm_top_tb_top;
    logic clk, sys_rst, test_mode, srv_timed, cli_fail, cli_valid, cli_ready, map_take;
    logic frame_sof, map_valid, mf_first_blk, prbs_take, prbs_last, nominal_just, dm_sof;
    logic dm_valid, dm_out_valid, crc_err, slot_req;
    logic path_alarm_indication, path_open_connection, path_locked_indication;
    logic [1:0] cli_hdr, map_hdr, dm_hdr, dm_out_hdr;
    logic [63:0] cli_data, map_data, dm_data, dm_out_data;
    logic [7:0] ovh_c15, payload_multiframe_counter, prbs_byte;
    logic [5:0] first_blk_offset;
    logic [2:0] path_monitor_field, tandem_monitor_one, tandem_monitor_two;
    logic [3:0] slot_delay;
    logic [65:0] outq[$];
    int error_cnt = 0;
    int n_compared = 0;
    int crc_err_cnt = 0;
    localparam logic [65:0] IDL = {`FGPM_HDR_CTRL, `FGPM_IDLE_BLK};
    localparam logic [65:0] STB = {`FGPM_HDR_CTRL, `FGPM_PREAMBLE, `FGPM_TYPE_START};
    localparam logic [65:0] LFB = {`FGPM_HDR_CTRL, `FGPM_LF_BLK};
    localparam logic [65:0] ERB = {`FGPM_HDR_CTRL, `FGPM_ERR_BLK};
    localparam logic [65:0] D1 = {`FGPM_HDR_DATA, 64'h0123_4567_89AB_CDEF};
    localparam logic [65:0] D2 = {`FGPM_HDR_DATA, 64'hFEDC_BA98_7654_3210};
    localparam logic [65:0] TB = {`FGPM_HDR_CTRL, 64'h0000_0000_0000_0087};

    fgpm_top i_fgpm_top (.clk, .sys_rst, .test_mode, .srv_timed, .cli_fail, .cli_valid,
        .cli_hdr, .cli_data, .cli_ready, .map_take, .frame_sof, .map_valid, .map_hdr,
        .map_data, .mf_first_blk, .ovh_c15, .payload_multiframe_counter, .first_blk_offset,
        .prbs_take, .prbs_byte, .prbs_last, .nominal_just, .dm_sof, .path_monitor_field,
        .tandem_monitor_one, .tandem_monitor_two, .dm_valid, .dm_hdr, .dm_data,
        .dm_out_valid, .dm_out_hdr, .dm_out_data, .crc_err, .path_alarm_indication,
        .path_open_connection, .path_locked_indication);
    fgpm_framer_model i_fgpm_framer_model (.clk, .sys_rst, .slot_req, .slot_delay,
        .map_take);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (dm_out_valid === 1'b1) outq.push_back({dm_out_hdr, dm_out_data});
        if (crc_err === 1'b1) crc_err_cnt++;
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [65:0] exp, input logic [65:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Independent CRC: octet 0 first, each octet from its top bit down
    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [63:0] d);
        logic fb;
        for (int i = 0; i < 64; i++) begin
            fb = c[31] ^ d[(i / 8) * 8 + 7 - (i % 8)];
            c = {c[30:0], 1'b0} ^ (fb ? `FGPM_CRC_POLY : 32'h0000_0000);
        end
        return c;
    endfunction

    function automatic logic [65:0] with_fcs(input logic [65:0] b, input logic [31:0] c);
        for (int k = 0; k < 32; k++) b[8 + k] = c[31 - k];
        return b;
    endfunction

    // Blocking on the falling edge: a reference argument takes no nonblocking update
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask

    task automatic map_one(input logic [65:0] b, input logic send, output logic [65:0] got,
        output logic first);
        int i;
        i = 0;
        if (send) begin
            while (cli_ready !== 1'b1 && i < 20) begin
                @(negedge clk);
                i++;
            end
            cli_valid <= 1'b1;
            {cli_hdr, cli_data} <= b;
            @(negedge clk);
            cli_valid <= 1'b0;
        end
        slot_req <= 1'b1;
        @(negedge clk);
        slot_req <= 1'b0;
        i = 0;
        while (map_valid !== 1'b1 && i < 30) begin
            @(negedge clk);
            i++;
        end
        got = {map_hdr, map_data};
        first = mf_first_blk;
        @(negedge clk);
    endtask

    task automatic t_overhead();
        logic [5:0] offs[11] = '{6'h00, 6'h24, 6'h06, 6'h2A, 6'h0C, 6'h30, 6'h12, 6'h36,
            6'h18, 6'h3C, 6'h1E};
        for (int m = 0; m < 12; m++) begin
            pulse(frame_sof);
            chk_vec("counter", 66'(m % 11), 66'(payload_multiframe_counter));
            chk_vec("offset", 66'(offs[m % 11]), 66'(first_blk_offset));
            chk_vec("ovh", 66'({1'b0, `FGPM_PT_PKT}), 66'({ovh_c15[7], ovh_c15[5:0]}));
        end
        $display("test overhead done");
    endtask

    task automatic t_pkt(input logic [3:0] dly, input logic follow_start, input logic top);
        logic [65:0] blks[4] = '{STB, D1, D2, TB};
        logic [65:0] got;
        logic first;
        logic [31:0] c;
        slot_delay = dly;
        c = `FGPM_CRC_INIT;
        for (int k = 0; k < 4; k++) begin
            map_one(blks[k], 1'b1, got, first);
            if (k > 0) c = crc_upd(c, blks[k][63:0]);
            chk_vec("map_blk", blks[k], got);
            if (k < 2 && top) chk_bit("mf_first", k == 0, first);
        end
        map_one(STB, follow_start, got, first);
        chk_vec("fcs_carrier", with_fcs(follow_start ? STB : IDL, c), got);
        $display("test packet map done");
    endtask

    task automatic feed(input logic [65:0] b);
        dm_valid <= 1'b1;
        {dm_hdr, dm_data} <= b;
        @(negedge clk);
    endtask

    task automatic t_sink(input logic bad);
        logic [65:0] exp[8];
        logic [31:0] c;
        c = crc_upd(crc_upd(crc_upd(`FGPM_CRC_INIT, D1[63:0]), D2[63:0]), TB[63:0]);
        exp = '{IDL, IDL, IDL, STB, D1 ^ 66'(bad), bad ? ERB : D2, TB, IDL};
        repeat (3) feed(IDL);
        feed(STB);
        // Cleared one edge late so an output launched before the fill is not queued
        outq.delete();
        crc_err_cnt = 0;
        feed(D1 ^ 66'(bad));
        feed(D2);
        feed(TB);
        feed(with_fcs(IDL, c));
        repeat (3) feed(IDL);
        dm_valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk_vec("sink_count", 66'd8, 66'(outq.size()));
        for (int k = 0; k < 8 && k < outq.size(); k++)
            chk_vec("sink_blk", exp[k], outq[k]);
        chk_vec("crc_err_pulses", 66'(bad), 66'(crc_err_cnt));
        $display("test sink done");
    endtask

    task automatic t_fail();
        logic [65:0] got;
        logic first;
        cli_fail <= 1'b1;
        srv_timed <= 1'b1;
        pulse(frame_sof);
        chk_bit("client_fail_flag", 1'b1, ovh_c15[7]);
        chk_bit("nominal_just", 1'b1, nominal_just);
        map_one(IDL, 1'b0, got, first);
        chk_vec("fail_block", LFB, got);
        cli_fail <= 1'b0;
        pulse(frame_sof);
        chk_bit("client_fail_flag", 1'b0, ovh_c15[7]);
        $display("test client fail done");
    endtask

    task automatic t_prbs();
        logic [30:0] s;
        logic [7:0] e;
        int n;
        s = `FGPM_PRBS_INIT;
        test_mode <= 1'b1;
        pulse(frame_sof);
        chk_vec("pt_test", 66'(`FGPM_PT_PRBS), 66'(ovh_c15[5:0]));
        prbs_take <= 1'b1;
        n = -1;
        for (int j = 0; j < 15200 && n < 0; j++) begin
            @(negedge clk);
            for (int b = 0; b < 8; b++) begin
                e = {e[6:0], s[30] ^ s[27]};
                s = {s[29:0], s[30] ^ s[27]};
            end
            if (j < 8) chk_vec("prbs_byte", 66'(e), 66'(prbs_byte));
            if (prbs_last === 1'b1) n = j;
        end
        prbs_take <= 1'b0;
        chk_vec("prbs_last_index", 66'd15167, 66'(n));
        test_mode <= 1'b0;
        $display("test prbs done");
    endtask

    task automatic t_maint();
        logic [2:0] codes[3] = '{`FGPM_STAT_AIS, `FGPM_STAT_OCI, `FGPM_STAT_LCK};
        for (int f = 0; f < 3; f++) begin
            for (int k = 0; k < 3; k++) begin
                path_monitor_field <= (f == 0) ? codes[k] : 3'h0;
                tandem_monitor_one <= (f == 1) ? codes[k] : 3'h0;
                tandem_monitor_two <= (f == 2) ? codes[k] : 3'h0;
                pulse(dm_sof);
                @(negedge clk);
                chk_vec("flags", 66'(3'b100 >> k), 66'({path_alarm_indication,
                    path_open_connection, path_locked_indication}));
                chk_bit("nominal_just", 1'b1, nominal_just);
                outq.delete();
                repeat (2) feed(IDL);
                dm_valid <= 1'b0;
                repeat (2) @(negedge clk);
                chk_bit("lf_seen", 1'b1, outq.size() > 0);
                if (outq.size() > 0) chk_vec("lf_block", LFB, outq[0]);
            end
        end
        {path_monitor_field, tandem_monitor_one, tandem_monitor_two} <= 9'h000;
        pulse(dm_sof);
        chk_bit("alarm_clear", 1'b0, path_alarm_indication);
        $display("test maintenance done");
    endtask

    initial begin
        {test_mode, srv_timed, cli_fail, cli_valid, frame_sof, prbs_take} = 6'h00;
        {dm_sof, dm_valid, slot_req} = 3'h0;
        {cli_hdr, cli_data, dm_hdr, dm_data} = '0;
        {path_monitor_field, tandem_monitor_one, tandem_monitor_two} = 9'h000;
        slot_delay = 4'h0;
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("cli_ready", 1'b1, cli_ready);
        chk_bit("map_valid", 1'b0, map_valid);
        t_overhead();
        t_pkt(4'h0, 1'b1, 1'b1);
        t_pkt(4'h5, 1'b0, 1'b0);
        t_sink(1'b0);
        t_sink(1'b1);
        t_fail();
        t_prbs();
        t_maint();
        report_and_stop();
    end

    // Whole run needs about 15500 cycles; allow over three times that
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule
